// *** core/rcb_ctrl.sv ***
// Controller end: queues commands, adds parity and drives the buffer link
`timescale 1ns/10ps
`include "rcb_params.svh"
module rcb_ctrl
    import rcb_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  resetn,
    rcb_if.ctrl        link,
    input  wire logic  cmd_valid,
    output logic       cmd_ready,
    input  wire logic  [`RCB_CMD_W-1:0] cmd_word,
    input  wire logic  [`RCB_CS_W-1:0] cmd_chip_sel,
    input  wire logic  cmd_bad_parity,
    input  wire logic  issue_enable,
    input  wire logic  [`RCB_PAIR_W-1:0] clk_enable_req,
    input  wire logic  [`RCB_PAIR_W-1:0] term_ctrl_req,
    output logic       link_ready,
    output logic       parity_fault_seen,
    output logic       [`RCB_ERR_CNT_W-1:0] parity_fault_count
);
    localparam int FW = `RCB_CMD_W + `RCB_CS_W + 1;

    rcb_ctrl_state_type     state;
    logic [`RCB_HOLD_W-1:0] hold_cnt;
    logic [FW-1:0]          fifo_out;
    logic                   fifo_valid;
    logic                   pop;
    rcb_cmd_type            pop_cmd;
    rcb_cs_type             pop_cs;
    logic                   pop_bad;
    logic                   fault_prev;

    assign pop        = fifo_valid & issue_enable & (state == RCB_RUN);
    assign pop_cmd    = fifo_out[FW-1 -: `RCB_CMD_W];
    assign pop_cs     = fifo_out[`RCB_CS_W:1];
    assign pop_bad    = fifo_out[0];
    assign link_ready = (state == RCB_RUN);

    rcb_fifo #(
        .WIDTH(FW),
        .DEPTH(`RCB_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .in_data   ({cmd_word, cmd_chip_sel, cmd_bad_parity}),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_out)
    );

    // Hold link low after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= RCB_HOLD_LOW;
            hold_cnt <= '0;
        end else begin
            case (state)
                RCB_HOLD_LOW: begin
                    hold_cnt <= hold_cnt + 1'h1;
                    if (hold_cnt >= `RCB_HOLD_W'(`RCB_ON_CYCLES - 1)) begin // [R13] [R15]
                        state <= RCB_RUN;
                    end
                end
                default: begin
                    state <= RCB_RUN;
                end
            endcase
        end
    end

    // Link drive; data and parity low in reset and hold, selects idle high so no check runs on the all-zero word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link.gated_cmd_in  <= '0; // [R14] [R16]
            link.chip_sel_in_0 <= 1'h1;
            link.chip_sel_in_1 <= 1'h1;
            link.parity_bit_in <= 1'h0;
        end else if (state != RCB_RUN) begin
            link.gated_cmd_in  <= '0; // [R13]
            link.chip_sel_in_0 <= 1'h1;
            link.chip_sel_in_1 <= 1'h1;
            link.parity_bit_in <= 1'h0;
        end else if (pop) begin
            link.gated_cmd_in  <= pop_cmd;
            link.chip_sel_in_0 <= pop_cs[0]; // [R3]
            link.chip_sel_in_1 <= pop_cs[1];
            link.parity_bit_in <= rcb_odd_fill(pop_cmd) ^ pop_bad; // [R7]
        end else begin
            link.chip_sel_in_0 <= 1'h1;
            link.chip_sel_in_1 <= 1'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link.clk_enable_in_0 <= 1'h0;
            link.clk_enable_in_1 <= 1'h0;
            link.term_ctrl_in_0  <= 1'h0;
            link.term_ctrl_in_1  <= 1'h0;
        end else begin
            link.clk_enable_in_0 <= clk_enable_req[0] & (state == RCB_RUN);
            link.clk_enable_in_1 <= clk_enable_req[1] & (state == RCB_RUN);
            link.term_ctrl_in_0  <= term_ctrl_req[0] & (state == RCB_RUN);
            link.term_ctrl_in_1  <= term_ctrl_req[1] & (state == RCB_RUN);
        end
    end

    // Fault watch: level and count of falling edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            parity_fault_seen  <= 1'h0;
            fault_prev         <= 1'h0;
            parity_fault_count <= '0;
        end else begin
            parity_fault_seen <= ~link.parity_fault_n;
            fault_prev        <= ~link.parity_fault_n;
            if (~link.parity_fault_n && !fault_prev && parity_fault_count != '1) begin
                parity_fault_count <= parity_fault_count + 1'h1;
            end
        end
    end
endmodule

// *** core/rcb_params.svh ***
// Constants of the registered command buffer and its controller
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH
`define RCB_CMD_W         22
`define RCB_PAR_W         21
`define RCB_CS_W          2
`define RCB_PAIR_W        2
`define RCB_CS_IDLE       2'h3
`define RCB_FIFO_DEPTH    8
`define RCB_ERR_HOLD      2'h2
`define RCB_ERR_CNT_W     8
`define RCB_CLK_NS        10
`define RCB_ON_TIME_NS    10
`define RCB_OFF_TIME_NS   15
`define RCB_ON_CYCLES     ((`RCB_ON_TIME_NS + `RCB_CLK_NS - 1) / `RCB_CLK_NS)
`define RCB_OFF_CYCLES    ((`RCB_OFF_TIME_NS + `RCB_CLK_NS - 1) / `RCB_CLK_NS)
`define RCB_HOLD_W        4
`endif

// *** core/rcb_pkg.sv ***
// Types and shared functions of the registered command buffer
`include "rcb_params.svh"
package rcb_pkg;
    typedef logic [`RCB_CMD_W-1:0]     rcb_cmd_type;
    typedef logic [`RCB_CS_W-1:0]      rcb_cs_type;
    typedef logic [`RCB_PAIR_W-1:0]    rcb_pair_type;
    typedef logic [`RCB_ERR_CNT_W-1:0] rcb_cnt_type;
    typedef enum logic {RCB_HOLD_LOW, RCB_RUN} rcb_ctrl_state_type;

    // Odd parity over the low command bits: returns 1 when an even number are high
    function automatic logic rcb_odd_fill(input rcb_cmd_type cmd);
        rcb_odd_fill = ~(^cmd[`RCB_PAR_W-1:0]);
    endfunction

    // Chip select window: at least one select low
    function automatic logic rcb_selected(input rcb_cs_type cs);
        rcb_selected = ~(&cs);
    endfunction
endpackage

// *** core/rcb_if.sv ***
// Link between the command controller and the registered buffer
`timescale 1ns/10ps
interface rcb_if (
    input wire logic clk
);
    import rcb_pkg::*;
    rcb_cmd_type gated_cmd_in;
    logic        chip_sel_in_0;
    logic        chip_sel_in_1;
    logic        clk_enable_in_0;
    logic        clk_enable_in_1;
    logic        term_ctrl_in_0;
    logic        term_ctrl_in_1;
    logic        parity_bit_in;
    logic        parity_fault_o;
    logic        parity_fault_oe;
    logic        parity_fault_n;

    // Open-drain wire with pull-up
    assign parity_fault_n = parity_fault_oe ? parity_fault_o : 1'h1;

    modport device (
        input  gated_cmd_in,
        input  chip_sel_in_0,
        input  chip_sel_in_1,
        input  clk_enable_in_0,
        input  clk_enable_in_1,
        input  term_ctrl_in_0,
        input  term_ctrl_in_1,
        input  parity_bit_in,
        output parity_fault_o,
        output parity_fault_oe
    );

    modport ctrl (
        output gated_cmd_in,
        output chip_sel_in_0,
        output chip_sel_in_1,
        output clk_enable_in_0,
        output clk_enable_in_1,
        output term_ctrl_in_0,
        output term_ctrl_in_1,
        output parity_bit_in,
        input  parity_fault_n
    );
endinterface

// *** core/rcb_fifo.sv ***
// Command FIFO with valid and ready on both sides
`timescale 1ns/10ps
module rcb_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'h1;
    endfunction

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= step(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= step(rd_ptr);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'h1;
        end else if (pop && !push) begin
            count <= count - 1'h1;
        end
    end
endmodule

// *** core/rcb_buffer.sv ***
// Device end: registered 1:1 command buffer with odd parity check
//
// Contract
// [R1] Clock enable and termination registered every edge
// [R2] Gated command updates only with a select low
// [R3] Controller drives a select low per command; rcb_ctrl passes cmd_chip_sel as given, even both high
// [R4] Any select low re-drives all gated inputs
// [R5] All outputs registered right after capture edge
// [R6] Everything registered on rising clock edge
// [R7] Controller keeps odd parity over bits 0-20
// [R8] Parity mismatch pulls fault output low
// [R9] Fault output stays asserted two cycles
// [R10] Fault output delayed one extra cycle
// [R11] Asynchronous reset clears state, outputs low
// [R12] Reset leaves fault output inactive high
// [R13] Controller holds inputs low after reset release
// [R14] Controller keeps inputs valid after reset entry
// [R15] Receiver activation time at most 10 ns
// [R16] Receiver deactivation time at most 15 ns
// [R17] Both selects high blocks gated output changes
// [R18] Parity checked only on selected edges
`timescale 1ns/10ps
`include "rcb_params.svh"
module rcb_buffer
    import rcb_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  resetn,
    rcb_if.device      link,
    output logic       [`RCB_CMD_W-1:0] gated_cmd_out,
    output logic       [`RCB_CS_W-1:0] chip_sel_out,
    output logic       [`RCB_PAIR_W-1:0] clk_enable_out,
    output logic       [`RCB_PAIR_W-1:0] term_ctrl_out,
    output logic       parity_fault_active,
    output logic       [`RCB_ERR_CNT_W-1:0] parity_fault_total
);
    rcb_cs_type  cs_now;
    logic        selected;
    logic        check_valid;
    logic        check_err;
    logic        err_delay;
    logic [1:0]  err_hold;
    logic        err_cap_cmd_par;
    rcb_cmd_type cap_cmd;
    logic        cap_par;

    assign cs_now   = {link.chip_sel_in_1, link.chip_sel_in_0};
    assign selected = rcb_selected(cs_now);

    // Gated command path
    always_ff @(posedge clk or negedge resetn) begin // [R6]
        if (!resetn) begin
            gated_cmd_out <= '0; // [R11]
        end else if (selected) begin
            gated_cmd_out <= link.gated_cmd_in; // [R2] [R4] [R5]
        end else begin
            gated_cmd_out <= gated_cmd_out; // [R17]
        end
    end

    // Chip select copies
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chip_sel_out <= '0; // [R11]
        end else begin
            chip_sel_out <= cs_now; // [R5]
        end
    end

    // Ungated clock enable and termination copies
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_enable_out <= '0; // [R11]
            term_ctrl_out  <= '0;
        end else begin
            clk_enable_out <= {link.clk_enable_in_1, link.clk_enable_in_0}; // [R1] [R5]
            term_ctrl_out  <= {link.term_ctrl_in_1, link.term_ctrl_in_0}; // [R1]
        end
    end

    // Parity capture on selected edges only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            check_valid <= 1'h0;
            cap_cmd     <= '0;
            cap_par     <= 1'h0;
        end else begin
            check_valid <= selected; // [R18]
            if (selected) begin
                cap_cmd <= link.gated_cmd_in;
                cap_par <= link.parity_bit_in;
            end
        end
    end

    // Controller keeps odd parity; a mismatch is an error
    assign err_cap_cmd_par = (rcb_odd_fill(cap_cmd) != cap_par); // [R7] [R8]

    // Basic check stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            check_err <= 1'h0; // [R12]
        end else begin
            check_err <= check_valid & err_cap_cmd_par; // [R8] [R18]
        end
    end

    // Extra stage for standard error timing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_delay <= 1'h0;
        end else begin
            err_delay <= check_err; // [R10]
        end
    end

    // Two-cycle error pulse; a new error restarts it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_hold <= 2'h0; // [R12]
        end else if (err_delay) begin
            err_hold <= `RCB_ERR_HOLD; // [R9]
        end else if (err_hold != 2'h0) begin
            err_hold <= err_hold - 2'h1; // [R9]
        end
    end

    // Open-drain drive: enable only to pull low
    assign link.parity_fault_o  = 1'h0;
    assign link.parity_fault_oe = (err_hold != 2'h0); // [R8] [R12]
    assign parity_fault_active  = (err_hold != 2'h0);

    // Saturating count of detected errors
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            parity_fault_total <= '0; // [R11]
        end else if (err_delay && parity_fault_total != '1) begin
            parity_fault_total <= parity_fault_total + 1'h1;
        end
    end
endmodule

// *** verification/rcb_assertions.sv ***
// Timing checks on the link between controller and buffer
`timescale 1ns/10ps
module rcb_assertions
    import rcb_pkg::*;
(
    input wire logic         clk,
    input wire logic         resetn,
    input wire rcb_cmd_type  gated_cmd_in,
    input wire logic         chip_sel_in_0,
    input wire logic         chip_sel_in_1,
    input wire logic         clk_enable_in_0,
    input wire logic         clk_enable_in_1,
    input wire logic         term_ctrl_in_0,
    input wire logic         term_ctrl_in_1,
    input wire logic         parity_bit_in,
    input wire logic         parity_fault_n,
    input wire rcb_cmd_type  gated_cmd_out,
    input wire rcb_cs_type   chip_sel_out,
    input wire rcb_pair_type clk_enable_out,
    input wire rcb_pair_type term_ctrl_out
);
    logic sel;
    logic bad;
    assign sel = !(chip_sel_in_0 && chip_sel_in_1);
    assign bad = resetn && sel && !(^{gated_cmd_in[20:0], parity_bit_in});
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    cke_copy_a: assert property (clk_enable_out == $past({clk_enable_in_1, clk_enable_in_0}))
        else $error("clock enable copy wrong");
    odt_copy_a: assert property (term_ctrl_out == $past({term_ctrl_in_1, term_ctrl_in_0}))
        else $error("termination copy wrong");
    sel_copy_a: assert property ($past(resetn) |-> chip_sel_out == $past({chip_sel_in_1, chip_sel_in_0}))
        else $error("chip select copy wrong");
    cmd_load_a: assert property (sel |=> gated_cmd_out == $past(gated_cmd_in))
        else $error("selected command not loaded");
    cmd_hold_a: assert property (!sel |=> $stable(gated_cmd_out))
        else $error("unselected command changed output");
    fault_time_a: assert property (bad |-> ##4 !parity_fault_n ##1 !parity_fault_n)
        else $error("fault pulse missing or late");
    fault_cause_a: assert property ($fell(parity_fault_n) |-> $past(bad, 4))
        else $error("fault without a bad selected edge");
    fault_width_a: assert property ($rose(parity_fault_n) |-> !$past(parity_fault_n, 2))
        else $error("fault pulse too short");
    fault_span_a: assert property (!parity_fault_n [*3] |-> ($past(bad, 4) || $past(bad, 5)))
        else $error("fault pulse too long");
    reset_clear_a: assert property (disable iff (1'b0)
        !resetn |-> gated_cmd_out == '0 && chip_sel_out == '0 && parity_fault_n)
        else $error("outputs not cleared in reset");
    cover property (bad);
    cover property (sel ##1 sel);
    cover property (!sel ##1 sel);
endmodule

// *** verification/test_ddr2_registered_cmd_buffer_parity.sv ***
// Self-checking bench for the controller and buffer pair
`timescale 1ns/10ps
module test_ddr2_registered_cmd_buffer_parity;
    import rcb_pkg::*;
    logic         clk;
    logic         resetn;
    logic         cmd_valid;
    logic         cmd_ready;
    rcb_cmd_type  cmd_word;
    rcb_cs_type   cmd_chip_sel;
    logic         cmd_bad_parity;
    logic         issue_enable;
    rcb_pair_type clk_enable_req;
    rcb_pair_type term_ctrl_req;
    logic         link_ready;
    logic         parity_fault_seen;
    rcb_cnt_type  parity_fault_count;
    rcb_cmd_type  gated_cmd_out;
    rcb_cs_type   chip_sel_out;
    rcb_pair_type clk_enable_out;
    rcb_pair_type term_ctrl_out;
    logic         parity_fault_active;
    rcb_cnt_type  parity_fault_total;
    logic         parity_fault_n;
    int           miscompares;
    int           checked;
    rcb_if rcb_if_i (.clk(clk));
    assign parity_fault_n = rcb_if_i.parity_fault_n;
    rcb_ctrl rcb_ctrl_i (.clk, .resetn, .link(rcb_if_i), .cmd_valid, .cmd_ready, .cmd_word, .cmd_chip_sel,
        .cmd_bad_parity, .issue_enable, .clk_enable_req, .term_ctrl_req, .link_ready, .parity_fault_seen,
        .parity_fault_count);
    rcb_buffer rcb_buffer_i (.clk, .resetn, .link(rcb_if_i), .gated_cmd_out, .chip_sel_out, .clk_enable_out,
        .term_ctrl_out, .parity_fault_active, .parity_fault_total);
    rcb_assertions rcb_assertions_i (.clk, .resetn, .gated_cmd_in(rcb_if_i.gated_cmd_in),
        .chip_sel_in_0(rcb_if_i.chip_sel_in_0), .chip_sel_in_1(rcb_if_i.chip_sel_in_1),
        .clk_enable_in_0(rcb_if_i.clk_enable_in_0), .clk_enable_in_1(rcb_if_i.clk_enable_in_1),
        .term_ctrl_in_0(rcb_if_i.term_ctrl_in_0), .term_ctrl_in_1(rcb_if_i.term_ctrl_in_1),
        .parity_bit_in(rcb_if_i.parity_bit_in), .parity_fault_n(rcb_if_i.parity_fault_n),
        .gated_cmd_out, .chip_sel_out, .clk_enable_out, .term_ctrl_out);

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_cmd(input rcb_cmd_type got, input rcb_cmd_type exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: command %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Offers one command; caller stands at a rising edge
    task automatic push(input rcb_cmd_type w, input rcb_cs_type cs, input logic bad, output logic took);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        cmd_chip_sel <= cs;
        cmd_bad_parity <= bad;
        @(negedge clk);
        took = cmd_ready;
        @(posedge clk);
    endtask

    task automatic t_select;
        logic took;
        int n;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            push(22'h2a5a5 ^ 22'(i), 2'(i), 1'b0, took);
            cmd_valid <= 1'b0;
            for (n = 0; n < 20 && gated_cmd_out !== (22'h2a5a5 ^ 22'(i)); n++) begin
                @(negedge clk);
            end
            cmp_cmd(gated_cmd_out, 22'h2a5a5 ^ 22'(i));
            cmp_val(8'(chip_sel_out), 8'(i));
            @(negedge clk);
            cmp_val(8'(chip_sel_out), 8'h03);
            repeat (3) @(negedge clk);
            cmp_cmd(gated_cmd_out, 22'h2a5a5 ^ 22'(i));
        end
    endtask

    task automatic t_ungated;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            clk_enable_req <= 2'(i);
            term_ctrl_req <= 2'(3 - i);
            repeat (4) @(negedge clk);
            cmp_val(8'(clk_enable_out), 8'(i));
            cmp_val(8'(term_ctrl_out), 8'(3 - i));
        end
    endtask

    task automatic t_parity;
        rcb_cnt_type base;
        rcb_cnt_type cnt_base;
        logic took;
        int n;
        int len;
        @(posedge clk);
        base = parity_fault_total;
        cnt_base = parity_fault_count;
        push(22'h3f0f0f, 2'h1, 1'b1, took);
        cmd_valid <= 1'b0;
        for (n = 0; n < 12 && parity_fault_n !== 1'b0; n++) begin
            @(negedge clk);
        end
        cmp_val(8'(n), 8'h06);
        cmp_val(8'(parity_fault_active), 8'h01);
        for (len = 0; len < 12 && parity_fault_n === 1'b0; len++) begin
            @(negedge clk);
        end
        cmp_val(8'(len), 8'h02);
        cmp_val(parity_fault_total, base + 8'h01);
        cmp_val(parity_fault_count, cnt_base + 8'h01);
        cmp_val(8'(parity_fault_seen), 8'h01);
        @(posedge clk);
        push(22'h200000, 2'h2, 1'b0, took);
        cmd_valid <= 1'b0;
        repeat (10) @(negedge clk);
        cmp_val(parity_fault_total, base + 8'h01);
        @(posedge clk);
        push(22'h0a5a5a, 2'h3, 1'b1, took);
        cmd_valid <= 1'b0;
        repeat (10) @(negedge clk);
        cmp_val(parity_fault_total, base + 8'h01);
        cmp_cmd(gated_cmd_out, 22'h200000);
    endtask

    task automatic t_fifo;
        logic took;
        int acc;
        int k;
        acc = 0;
        k = 0;
        @(posedge clk);
        issue_enable <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            push(22'h15a00 + 22'(i), 2'h2, 1'b0, took);
            acc += int'(took === 1'b1);
        end
        cmd_valid <= 1'b0;
        issue_enable <= 1'b1;
        cmp_val(8'(acc), 8'h08);
        repeat (20) begin
            @(negedge clk);
            if (chip_sel_out !== 2'h3 && k < 8) begin
                cmp_cmd(gated_cmd_out, 22'h15a00 + 22'(k));
                k++;
            end
        end
        cmp_val(8'(k), 8'h08);
    endtask

    task automatic t_reset;
        logic took;
        int n;
        @(posedge clk);
        push(22'h0f0f0e, 2'h2, 1'b1, took);
        cmd_valid <= 1'b0;
        for (n = 0; n < 12 && parity_fault_n !== 1'b0; n++) begin
            @(negedge clk);
        end
        @(posedge clk);
        resetn <= 1'b0;
        @(negedge clk);
        cmp_cmd(gated_cmd_out, 22'h0);
        cmp_val({chip_sel_out, clk_enable_out, term_ctrl_out, 2'h0}, 8'h00);
        cmp_val(8'(rcb_if_i.parity_fault_n), 8'h01);
        cmp_val(8'(link_ready), 8'h00);
        @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        cmp_val(8'(link_ready), 8'h01);
        cmp_val(parity_fault_total, 8'h00);
        cmp_val(8'(chip_sel_out), 8'h03);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100000;
        miscompares++;
        end_sim;
    end

    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_word = 22'h0;
        cmd_chip_sel = 2'h3;
        cmd_bad_parity = 1'b0;
        issue_enable = 1'b1;
        clk_enable_req = 2'h0;
        term_ctrl_req = 2'h0;
        miscompares = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        t_select;
        t_ungated;
        t_parity;
        t_fifo;
        t_reset;
        t_select;
        end_sim;
    end
endmodule
